//--- common/usb_split_pkg.sv
// register map, field layout and encodings of the channel sequencer
// assumes a 32-bit ahb-lite register bus with word-aligned registers
package usb_split_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_HUB    = 8'h04;
    localparam logic [7:0] OFS_COUNT  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_RUN    = 0;
    localparam int CTRL_DIR    = 1;
    localparam int CTRL_TYPE   = 3;
    localparam int CTRL_SPEED  = 5;
    localparam int CTRL_PORT   = 7;
    localparam int HUB_PORTNUM = 8;
    localparam int STAT_ACK    = 0;
    localparam int STAT_ERR    = 1;
    localparam int STAT_CHG    = 2;
    localparam int STAT_CODE   = 4;
    localparam int STAT_ERRCNT = 8;
    localparam int STAT_BUSY   = 10;

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [1:0]  RETRY_LIMIT  = 2'h3;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {DIR_SETUP = 2'b00, DIR_IN = 2'b01, DIR_OUT = 2'b10} dir_t;
    typedef enum logic [1:0] {TT_CTRL = 2'b00, TT_ISO = 2'b01, TT_BULK = 2'b10, TT_INTR = 2'b11} xfer_type_t;
    typedef enum logic [1:0] {SPD_FS = 2'b00, SPD_LS = 2'b01, SPD_HS = 2'b10} speed_t;
    typedef enum logic [1:0] {PM_DIRECT = 2'b00, PM_FS_HUB = 2'b01, PM_HS_HUB = 2'b10} port_mode_t;
    typedef enum logic [2:0] {CC_NONE = 3'b000, CC_RETRY = 3'b001, CC_STALL = 3'b010,
                              CC_BADTYPE = 3'b011} code_t;
    typedef enum logic [1:0] {PK_SETUP = 2'b00, PK_IN = 2'b01, PK_OUT = 2'b10, PK_ACK = 2'b11} pkt_kind_t;
    typedef enum logic [1:0] {SP_NONE = 2'b00, SP_START = 2'b01, SP_COMPLETE = 2'b10} split_t;
    typedef enum logic [1:0] {RS_OK = 2'b00, RS_NAK = 2'b01, RS_STALL = 2'b10, RS_ERR = 2'b11} result_t;

endpackage : usb_split_pkg

//--- design/ahb_reg_port.sv
// ahb-lite slave handshake for the channel register file
// assumes one master, single word transfers, hready fed back from hreadyout
`timescale 1ns/10ps
module ahb_reg_port (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // ahb-lite address phase
    input  wire logic       hsel_i,
    input  wire logic       hready_i,
    input  wire logic [1:0] htrans_i,
    input  wire logic       hwrite_i,
    input  wire logic [7:0] haddr_i,
    // to the register file
    output logic            wr_stb_o,
    output logic            rd_stb_o,
    output logic [7:0]      addr_o,
    output logic            hreadyout_o
);

    // ----------------------------------------------------------------
    // address phase capture
    // ----------------------------------------------------------------
    logic       wr_pend;
    logic       rd_pend;
    logic [7:0] addr;
    wire        take = hsel_i & hready_i & htrans_i[1];

    // reads take one wait state so a write just before is always seen
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend     <= 1'b0;
            rd_pend     <= 1'b0;
            addr        <= 8'h00;
            hreadyout_o <= 1'b1;
        end else begin
            wr_pend     <= take & hwrite_i;
            rd_pend     <= take & ~hwrite_i;
            hreadyout_o <= ~(take & ~hwrite_i);
            if (take) begin
                addr <= haddr_i;
            end
        end
    end

    assign wr_stb_o = wr_pend;
    assign rd_stb_o = rd_pend;
    assign addr_o   = addr;

endmodule : ahb_reg_port

//--- design/usb_host_speed_split_ctl.sv
// host channel sequencer: low-speed, preamble and split transactions
// assumes a packet engine on the same clock that sends tokens and data on request
// and reports one result per request; firmware runs control stages one by one
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps

module usb_host_speed_split_ctl (
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    // ahb-lite slave
    input  wire logic        HSEL_I,
    input  wire logic        HREADY_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [31:0] HWDATA_I,
    output logic [31:0]      HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // packet engine requests
    output logic             PKT_REQ_O,
    output logic [1:0]       PKT_KIND_O,
    output logic [1:0]       PKT_SPLIT_O,
    output logic             PKT_PRE_O,
    output logic             PKT_LS_O,
    output logic             PKT_HS_O,
    output logic [6:0]       PKT_HUB_ADDR_O,
    output logic [6:0]       PKT_HUB_PORT_O,
    // packet engine results and received data
    input  wire logic        PKT_DONE_I,
    input  wire logic [1:0]  PKT_RESULT_I,
    input  wire logic        RX_VALID_I,
    input  wire logic [7:0]  RX_DATA_I,
    // channel buffer
    output logic             BUF_WR_O,
    output logic [7:0]       BUF_DATA_O,
    output logic             BUF_COMMIT_O,
    output logic             BUF_DISCARD_O
);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] reg_addr;
    logic       hready_q;

    ahb_reg_port u_port (
        .clk_i       (CLK_SYS_I),
        .rst_i       (RST_I),
        .hsel_i      (HSEL_I),
        .hready_i    (HREADY_I),
        .htrans_i    (HTRANS_I),
        .hwrite_i    (HWRITE_I),
        .haddr_i     (HADDR_I[7:0]),
        .wr_stb_o    (wr_stb),
        .rd_stb_o    (rd_stb),
        .addr_o      (reg_addr),
        .hreadyout_o (hready_q)
    );

    assign HREADYOUT_O = hready_q;

    // ----------------------------------------------------------------
    // channel settings
    // ----------------------------------------------------------------
    logic        transfer_run;
    logic [1:0]  transaction_direction;
    logic [1:0]  xfer_type;
    logic [1:0]  channel_speed_select;
    logic [1:0]  port_mode;
    logic [6:0]  hub_bus_address;
    logic [6:0]  hub_port;
    logic [15:0] transfer_byte_count;
    logic        transaction_ack_flag;
    logic        transaction_error_flag;
    logic        condition_changed_flag;
    logic [2:0]  completion_code;
    logic [1:0]  err_count;
    wire wr_ctrl   = wr_stb & (reg_addr == usb_split_pkg::OFS_CTRL);
    wire wr_hub    = wr_stb & (reg_addr == usb_split_pkg::OFS_HUB);
    wire wr_count  = wr_stb & (reg_addr == usb_split_pkg::OFS_COUNT);
    wire wr_status = wr_stb & (reg_addr == usb_split_pkg::OFS_STATUS);

    // ----------------------------------------------------------------
    // transaction mode decode
    // ----------------------------------------------------------------
    wire spd_ls   = channel_speed_select == usb_split_pkg::SPD_LS;
    wire spd_hs   = channel_speed_select == usb_split_pkg::SPD_HS;
    wire is_split = (port_mode == usb_split_pkg::PM_HS_HUB) & ~spd_hs;
    wire is_pre   = (port_mode == usb_split_pkg::PM_FS_HUB) & spd_ls;
    wire ls_timed = (port_mode == usb_split_pkg::PM_DIRECT) & spd_ls;
    wire type_ok  = ~spd_ls | (xfer_type == usb_split_pkg::TT_CTRL)
                  | (xfer_type == usb_split_pkg::TT_INTR);
    wire dir_in   = transaction_direction == usb_split_pkg::DIR_IN;
    wire iso      = xfer_type == usb_split_pkg::TT_ISO;
    wire iso_out  = iso & (transaction_direction == usb_split_pkg::DIR_OUT);
    wire ends_err = ~iso;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_REQ   = 3'b001,
        ST_WAIT  = 3'b010,
        ST_HSK   = 3'b011,
        ST_HWAIT = 3'b100
    } state_t;

    state_t     state;
    logic [1:0] split_phase;
    wire res_ok    = PKT_DONE_I & (PKT_RESULT_I == usb_split_pkg::RS_OK);
    wire res_nak   = PKT_DONE_I & (PKT_RESULT_I == usb_split_pkg::RS_NAK);
    wire res_stall = PKT_DONE_I & (PKT_RESULT_I == usb_split_pkg::RS_STALL);
    wire res_err   = PKT_DONE_I & (PKT_RESULT_I == usb_split_pkg::RS_ERR);
    wire in_ss     = split_phase == usb_split_pkg::SP_START;
    wire in_wait   = state == ST_WAIT;
    wire err_final = (err_count == usb_split_pkg::RETRY_LIMIT - 2'h1) & ends_err;

    // start-split of a non-iso-out split is only an intermediate step
    wire step_cs   = in_wait & res_ok & is_split & in_ss & ~iso_out;
    wire need_hsk  = in_wait & res_ok & dir_in & ~is_split;
    wire success   = (in_wait & res_ok & ~step_cs & ~need_hsk)
                   | ((state == ST_HWAIT) & PKT_DONE_I);
    wire fail_err  = in_wait & res_err;
    wire fail_stop = (in_wait & res_stall) | (fail_err & err_final);
    wire bad_start = (state == ST_IDLE) & transfer_run & ~type_ok;
    wire run_clear = success | fail_stop | bad_start;

    wire [1:0] first_kind = transaction_direction;
    wire [1:0] first_split = is_split ? usb_split_pkg::SP_START : usb_split_pkg::SP_NONE;

    // control stages are one transaction each; firmware picks the direction
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            state       <= ST_IDLE;
            split_phase <= usb_split_pkg::SP_NONE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (transfer_run & type_ok) begin
                        state       <= ST_REQ;
                        split_phase <= first_split;
                    end
                end
                ST_REQ: begin
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (step_cs) begin
                        split_phase <= usb_split_pkg::SP_COMPLETE;
                        state       <= ST_REQ;
                    end else if (need_hsk) begin
                        state <= ST_HSK;
                    end else if (success | fail_stop) begin
                        state <= ST_IDLE;
                    end else if (PKT_DONE_I) begin
                        state <= ST_REQ;
                    end
                end
                ST_HSK: begin
                    state <= ST_HWAIT;
                end
                ST_HWAIT: begin
                    if (PKT_DONE_I) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // packet engine request
    // ----------------------------------------------------------------
    wire issue = (state == ST_REQ) | (state == ST_HSK);

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            PKT_REQ_O      <= 1'b0;
            PKT_KIND_O     <= usb_split_pkg::PK_SETUP;
            PKT_SPLIT_O    <= usb_split_pkg::SP_NONE;
            PKT_PRE_O      <= 1'b0;
            PKT_LS_O       <= 1'b0;
            PKT_HS_O       <= 1'b0;
            PKT_HUB_ADDR_O <= 7'h00;
            PKT_HUB_PORT_O <= 7'h00;
        end else begin
            PKT_REQ_O <= issue;
            if (issue) begin
                PKT_KIND_O     <= (state == ST_HSK) ? usb_split_pkg::PK_ACK : first_kind;
                PKT_SPLIT_O    <= split_phase;
                PKT_PRE_O      <= is_pre;
                PKT_LS_O       <= ls_timed | is_pre;
                PKT_HS_O       <= port_mode == usb_split_pkg::PM_HS_HUB;
                PKT_HUB_ADDR_O <= hub_bus_address;
                PKT_HUB_PORT_O <= hub_port;
            end
        end
    end

    // ----------------------------------------------------------------
    // channel buffer
    // ----------------------------------------------------------------
    // data is staged; only a successful transaction commits it
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            BUF_WR_O      <= 1'b0;
            BUF_DATA_O    <= 8'h00;
            BUF_COMMIT_O  <= 1'b0;
            BUF_DISCARD_O <= 1'b0;
        end else begin
            BUF_WR_O      <= in_wait & dir_in & RX_VALID_I;
            BUF_DATA_O    <= RX_DATA_I;
            BUF_COMMIT_O  <= success;
            BUF_DISCARD_O <= in_wait & PKT_DONE_I & ~res_ok;
        end
    end

    // ----------------------------------------------------------------
    // settings and status registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            transfer_run          <= usb_split_pkg::CTRL_RESET[usb_split_pkg::CTRL_RUN];
            transaction_direction <= usb_split_pkg::DIR_SETUP;
            xfer_type             <= usb_split_pkg::TT_CTRL;
            channel_speed_select  <= usb_split_pkg::SPD_FS;
            port_mode             <= usb_split_pkg::PM_DIRECT;
        end else if (wr_ctrl) begin
            transfer_run          <= HWDATA_I[usb_split_pkg::CTRL_RUN];
            transaction_direction <= HWDATA_I[usb_split_pkg::CTRL_DIR +: 2];
            xfer_type             <= HWDATA_I[usb_split_pkg::CTRL_TYPE +: 2];
            channel_speed_select  <= HWDATA_I[usb_split_pkg::CTRL_SPEED +: 2];
            port_mode             <= HWDATA_I[usb_split_pkg::CTRL_PORT +: 2];
        end else if (run_clear) begin
            transfer_run <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            hub_bus_address     <= 7'h00;
            hub_port            <= 7'h00;
            transfer_byte_count <= usb_split_pkg::COUNT_RESET;
        end else begin
            if (wr_hub) begin
                hub_bus_address <= HWDATA_I[6:0];
                hub_port        <= HWDATA_I[usb_split_pkg::HUB_PORTNUM +: 7];
            end
            if (wr_count) begin
                transfer_byte_count <= HWDATA_I[15:0];
            end
        end
    end

    // status flags: hardware set wins over a write-one clear in the same cycle
    wire [2:0] flag_clr = wr_status ? HWDATA_I[2:0] : 3'h0;
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            transaction_ack_flag   <= 1'b0;
            transaction_error_flag <= 1'b0;
            condition_changed_flag <= 1'b0;
            completion_code        <= usb_split_pkg::CC_NONE;
            err_count              <= 2'h0;
        end else begin
            transaction_ack_flag   <= success | (transaction_ack_flag & ~flag_clr[0]);
            transaction_error_flag <= fail_err | (transaction_error_flag & ~flag_clr[1]);
            condition_changed_flag <= fail_stop | bad_start
                                    | (condition_changed_flag & ~flag_clr[2]);
            if (success) begin
                completion_code <= usb_split_pkg::CC_NONE;
                err_count       <= 2'h0;
            end else if (in_wait & res_stall) begin
                completion_code <= usb_split_pkg::CC_STALL;
            end else if (fail_err) begin
                completion_code <= usb_split_pkg::CC_RETRY;
                err_count       <= err_final ? 2'h0 : err_count + 2'h1;
            end else if (bad_start) begin
                completion_code <= usb_split_pkg::CC_BADTYPE;
            end
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    wire [31:0] rd_ctrl = {23'h0, port_mode, channel_speed_select, xfer_type,
                           transaction_direction, transfer_run};
    wire [31:0] rd_hub  = {17'h0, hub_port, 1'b0, hub_bus_address};
    wire [31:0] rd_stat = {21'h0, state != ST_IDLE, err_count, 1'b0, completion_code,
                           1'b0, condition_changed_flag, transaction_error_flag,
                           transaction_ack_flag};
    wire [31:0] rd_mux  = (reg_addr == usb_split_pkg::OFS_CTRL)   ? rd_ctrl :
                          (reg_addr == usb_split_pkg::OFS_HUB)    ? rd_hub :
                          (reg_addr == usb_split_pkg::OFS_COUNT)  ? {16'h0, transfer_byte_count} :
                          (reg_addr == usb_split_pkg::OFS_STATUS) ? rd_stat : 32'h0000_0000;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            HRDATA_O <= 32'h0000_0000;
            HRESP_O  <= 1'b0;
        end else begin
            HRESP_O <= 1'b0;
            if (rd_stb) begin
                HRDATA_O <= rd_mux;
            end
        end
    end

endmodule : usb_host_speed_split_ctl

//--- bench/pkt_engine_model.sv
// packet engine stand-in: answers each request delay_i + 2 cycles after req_i rises
// assumes one request outstanding and the sequencer's own clock
`timescale 1ns/10ps
module pkt_engine_model (
    // requests from the sequencer, result chosen by the bench
    input  wire logic       clk_i, rst_i, req_i,
    input  wire logic [1:0] kind_i, result_i,
    input  wire logic [3:0] delay_i,
    // answers
    output logic            done_o, rx_valid_o,
    output logic [1:0]      result_o,
    output logic [7:0]      rx_data_o
);
    logic [3:0] cnt = 4'h0;
    logic       busy = 1'h0;
    logic       is_in = 1'h0;
    initial {done_o, rx_valid_o, result_o, rx_data_o} = '0;
    // idle result and data lines toggle so a stale value never passes for data
    always @(posedge clk_i) begin
        done_o     <= busy && cnt == 4'h0;
        rx_valid_o <= busy && is_in && cnt == 4'h1;
        result_o   <= (busy && cnt == 4'h0) ? result_i : ~result_o;
        rx_data_o  <= (busy && is_in && cnt == 4'h1) ? 8'h5A : ~rx_data_o;
        cnt        <= req_i ? delay_i : cnt - {3'h0, cnt != 4'h0};
        busy       <= !rst_i && (req_i || (busy && cnt != 4'h0));
        if (req_i) is_in <= kind_i == 2'h1;
    end
endmodule : pkt_engine_model

//--- bench/usb_split_chk_sva.sv
// concurrent checks on the packet, buffer and bus response ports
// assumes one clock domain with an active-high reset
`timescale 1ns/10ps
module usb_split_chk (
    // watched ports
    input wire logic       CLK_SYS_I, RST_I, HRESP_O, PKT_REQ_O, PKT_PRE_O, PKT_LS_O, PKT_HS_O, PKT_DONE_I,
    input wire logic       BUF_COMMIT_O,
    input wire logic [1:0] PKT_KIND_O, PKT_SPLIT_O, PKT_RESULT_I
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    a_resp_okay: assert property (HRESP_O == 1'h0)
        else $error("bus response not okay");
    a_req_pulse: assert property (PKT_REQ_O |=> !PKT_REQ_O)
        else $error("request too long");
    a_req_hold: assert property (!PKT_REQ_O |-> $stable({PKT_KIND_O, PKT_SPLIT_O, PKT_PRE_O, PKT_LS_O}))
        else $error("request fields moved");
    a_pre_rates: assert property (PKT_REQ_O && PKT_PRE_O |-> PKT_LS_O && !PKT_HS_O && PKT_SPLIT_O == 2'h0)
        else $error("preamble at wrong rate");
    a_split_hs: assert property (PKT_REQ_O && PKT_SPLIT_O != 2'h0 |-> PKT_HS_O)
        else $error("split without high speed");
    a_err_nocommit: assert property (PKT_DONE_I && PKT_RESULT_I == 2'h3 |=> !BUF_COMMIT_O [*2])
        else $error("buffer updated after error");
    a_commit_ok: assert property (BUF_COMMIT_O |-> $past(PKT_DONE_I) && $past(PKT_RESULT_I) == 2'h0)
        else $error("buffer updated without good result");
    a_commit_pulse: assert property (BUF_COMMIT_O |=> !BUF_COMMIT_O)
        else $error("buffer update held");
endmodule : usb_split_chk
bind usb_host_speed_split_ctl usb_split_chk chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .HRESP_O(HRESP_O),
    .PKT_REQ_O(PKT_REQ_O), .PKT_PRE_O(PKT_PRE_O), .PKT_LS_O(PKT_LS_O), .PKT_HS_O(PKT_HS_O), .PKT_DONE_I(PKT_DONE_I),
    .BUF_COMMIT_O(BUF_COMMIT_O), .PKT_KIND_O(PKT_KIND_O), .PKT_SPLIT_O(PKT_SPLIT_O), .PKT_RESULT_I(PKT_RESULT_I));

//--- bench/usb_host_speed_split_ctl_bench.sv
// bench: ahb-lite master, engine model, channel scenarios
// assumes one transaction per transfer_run write
`timescale 1ns/10ps
module usb_host_speed_split_ctl_bench;
    logic        clk = 1'h0, rst = 1'h1, hw = 1'h0, rdy, req, pre, ls, hs, done, rxv, bwr, bcom, bdis;
    logic [1:0]  ht = 2'h0, kind, spl, rsl, res = 2'h0;
    logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, q;
    logic [6:0]  hub_a, hub_p;
    logic [7:0]  rxd, bd, staged;
    logic [3:0]  dly = 4'h1;
    logic [27:0] trace;
    int          fails = 0, cmp_count = 0, commits, discards;
    usb_host_speed_split_ctl dut (.CLK_SYS_I(clk), .RST_I(rst), .HSEL_I(1'h1), .HREADY_I(rdy), .HTRANS_I(ht),
        .HWRITE_I(hw), .HSIZE_I(3'h2), .HADDR_I(ha), .HWDATA_I(hwd), .HRDATA_O(hrd), .HREADYOUT_O(rdy),
        .HRESP_O(), .PKT_REQ_O(req), .PKT_KIND_O(kind), .PKT_SPLIT_O(spl), .PKT_PRE_O(pre), .PKT_LS_O(ls),
        .PKT_HS_O(hs), .PKT_HUB_ADDR_O(hub_a), .PKT_HUB_PORT_O(hub_p), .PKT_DONE_I(done), .PKT_RESULT_I(rsl),
        .RX_VALID_I(rxv), .RX_DATA_I(rxd), .BUF_WR_O(bwr), .BUF_DATA_O(bd), .BUF_COMMIT_O(bcom), .BUF_DISCARD_O(bdis));
    pkt_engine_model peer (.clk_i(clk), .rst_i(rst), .req_i(req), .kind_i(kind), .result_i(res),
        .delay_i(dly), .done_o(done), .rx_valid_o(rxv), .result_o(rsl), .rx_data_o(rxd));
    always #5 clk = ~clk;
    // request log: the packet order shows only at the ports, so keep it
    always @(posedge clk) begin
        if (req) trace <= {trace[20:0], kind, spl, pre, ls, hs};
        if (bcom) commits <= commits + 1;
        if (bdis) discards <= discards + 1;
        if (bwr) staged <= bd;
    end
    task automatic cmp(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) fails++;
        if (g !== e) $display("wrong value %s expected %h seen %h", nm, e, g);
    endtask : cmp
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        ht <= 2'h2;
        ha <= {24'h0, a};
        hw <= w;
        do @(posedge clk); while (rdy !== 1'h1);
        ht <= 2'h0;
        hwd <= d;
        do @(posedge clk); while (rdy !== 1'h1);
        q = hrd;
    endtask : bus
    function automatic logic [31:0] mk(input logic [1:0] d, t, s, p);
        return {23'h0, p, s, t, d, 1'h1};
    endfunction : mk
    // one transaction: clear flags, start, poll until run drops, judge
    task automatic xfer(input string nm, input logic [31:0] c, input logic [1:0] r, input logic [27:0] et,
                        input logic [6:0] es);
        res <= r;
        bus(1'h1, 8'h0C, 32'h7);
        trace = 28'h0;
        commits = 0;
        discards = 0;
        staged = 8'h00;
        bus(1'h1, 8'h00, c);
        do bus(1'h0, 8'h00, 32'h0); while (q[0]);
        bus(1'h0, 8'h0C, 32'h0);
        cmp({nm, " trace"}, 32'(et), 32'(trace));
        cmp({nm, " status"}, 32'(es), 32'(q[6:0]));
        cmp({nm, " commit"}, 32'(es[0]), commits);
        $display("test %s ended", nm);
    endtask : xfer
    task automatic t_regs;
        bus(1'h0, 8'h0C, 32'h0);
        cmp("status reset", 32'h0, q);
        bus(1'h1, 8'h04, 32'h315);
        bus(1'h1, 8'h08, 32'hABCD);
        bus(1'h0, 8'h10, 32'h0);
        cmp("unmapped", 32'h0, q);
        bus(1'h0, 8'h04, 32'h0);
        cmp("hub", 32'h315, q);
        bus(1'h0, 8'h08, 32'h0);
        cmp("count", 32'hABCD, q);
        $display("test regs ended");
    endtask : t_regs
    task automatic t_low_speed;
        xfer("ls direct", mk(1, 3, 1, 0), 2'h0, {7'h22, 7'h62}, 7'h1);
        xfer("ls hub", mk(1, 3, 1, 1), 2'h0, {7'h26, 7'h66}, 7'h1);
        cmp("rx byte", 32'h5A, 32'(staged));
        xfer("ls bulk", mk(1, 2, 1, 0), 2'h0, 28'h0, 7'h34);
    endtask : t_low_speed
    task automatic t_split;
        dly <= 4'h6;
        xfer("split", mk(2, 3, 0, 2), 2'h0, {7'h49, 7'h51}, 7'h1);
        cmp("hub out", 32'h315, 32'({hub_p, 1'h0, hub_a}));
        dly <= 4'h1;
        xfer("iso out", mk(2, 1, 0, 2), 2'h0, 7'h49, 7'h1);
        xfer("split err", mk(2, 2, 0, 2), 2'h3, {3{7'h49}}, 7'h16);
        cmp("split err discards", 32'h3, discards);
    endtask : t_split
    // two split errors, then a clean finish: the run survives and the error count restarts
    task automatic t_recover;
        res <= 2'h3;
        dly <= 4'h6;
        bus(1'h1, 8'h0C, 32'h7);
        trace = 28'h0;
        discards = 0;
        bus(1'h1, 8'h00, mk(2, 2, 0, 2));
        wait (discards == 2);
        res <= 2'h0;
        bus(1'h0, 8'h0C, 32'h0);
        cmp("recover count", 32'h6, 32'(q[10:8]));
        do bus(1'h0, 8'h00, 32'h0); while (q[0]);
        bus(1'h0, 8'h0C, 32'h0);
        cmp("recover status", 32'h3, 32'(q[10:0]));
        cmp("recover trace", 32'({7'h49, 7'h49, 7'h49, 7'h51}), 32'(trace));
        dly <= 4'h1;
        $display("test recover ended");
    endtask : t_recover
    task automatic t_control;
        xfer("setup", mk(0, 0, 0, 0), 2'h0, 28'h0, 7'h1);
        xfer("out data", mk(2, 0, 0, 0), 2'h0, 7'h40, 7'h1);
        bus(1'h1, 8'h08, 32'h0);
        bus(1'h0, 8'h08, 32'h0);
        cmp("count zero", 32'h0, q);
        xfer("in status", mk(1, 0, 0, 0), 2'h0, {7'h20, 7'h60}, 7'h1);
    endtask : t_control
    task automatic tally_and_finish(input int extra);
        fails += extra;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_regs();
        t_low_speed();
        t_split();
        t_recover();
        t_control();
        tally_and_finish(0);
    end
    // a hung poll loop ends here; the whole run needs far less
    initial #300000 tally_and_finish(1);
endmodule : usb_host_speed_split_ctl_bench
